// File: hw/watchdog_timer_with_reload.sv
// Overview of operation
// - Watchdog is a 16-bit up counter stepping on each prescaled clock tick.
// - Two cascaded 8-bit halves; high loads preset, low clears on service.
// - Count readable through a read-only register; writes leave it unchanged.
// - Prescale bit 0 selects clock divided by 2, bit 1 divided by 128.
// - Overflow flag set by hardware on overflow, cleared by hard reset, software reset or service.
// - Control: preset in upper byte, flag bit 1 read-only, prescale bit 0.
// - Control reads 0002 after watchdog reset, 0000 after other resets.
// - After any reset but a bootstrap hard reset the watchdog runs from zero at clock divided by two.
// - Disable works only before the first end-of-init or service command.
// - Counting continues during processor idle mode unless disabled.
// - Unserviced wrap starts internal reset, drives reset-out low, sets flag.
// - Before resetting, finish a safe external bus cycle, else abort it.
// - Service clears low byte, loads preset high, clears flag; counts on.
// - Malformed service command raises protection fault and does not service.
// - Service to overflow takes 2^(1+6*prescale)*(65536-preset*256) clocks.
// - Hard reset selecting the bootstrap loader leaves the watchdog disabled.
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_with_reload #(
  parameter int RESET_OUT_LEN = wdt_pkg::RESET_OUT_CYCLES
) (
  // Clock and hardware reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // AXI4-Lite write address and data
  input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Core side
  input  wire logic                       sw_reset_req,
  input  wire logic                       idle_mode,
  output logic                            protection_fault_trap,
  output logic                            system_reset_req,
  // Pins
  input  wire logic                       boot_loader_sel,
  input  wire logic                       ext_ready_n,
  output logic                            reset_out_pin_n,
  // External bus controller
  input  wire logic                       ext_bus_busy,
  input  wire logic                       ext_bus_uses_ready,
  input  wire logic                       ext_bus_waits_done,
  output logic                            ext_bus_abort,
  // Interrupt
  output logic                            irq
);
  import wdt_pkg::*;

  typedef enum {ST_RUN, ST_BUS_WAIT, ST_RESET_SEQ} seq_e;

  if (RESET_OUT_LEN < 1 || RESET_OUT_LEN > 65535) begin : g_len_check
    $error("RESET_OUT_LEN out of range");
  end

  seq_e                seq_reg;
  logic [COUNT_W-1:0]  count_reg;
  logic [PRE_W-1:0]    pre_reg;
  logic [HALF_W-1:0]   reload_reg;
  logic                prescale_reg;
  logic                flag_reg;
  logic                enabled_reg;
  logic                dis_window_reg;
  logic [1:0]          strap_wait_reg;
  logic [15:0]         seq_cnt_reg;
  logic [IRQ_W-1:0]    irq_stat_reg;
  logic [IRQ_W-1:0]    irq_en_reg;
  logic                boot_s1_reg;
  logic                boot_s2_reg;
  logic                rdy_s1_reg;
  logic                rdy_s2_reg;

  // Write channel: address and data may arrive in either order
  logic [IDX_W-1:0]    wr_idx_reg;
  logic [31:0]         wr_data_reg;
  logic [3:0]          wr_strb_reg;
  logic                wr_go;
  logic                rd_go;
  logic [IDX_W-1:0]    rd_idx;

  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  // Decoded write effects
  logic    wr_ctrl;
  logic    wr_cmd;
  logic    key_ok;
  cmd_e    cmd;
  logic    do_service;
  logic    do_disable;
  logic    do_end_init;
  logic    bad_cmd;
  logic    tick;
  logic    overflow;
  logic    soft_init;
  logic    wdt_reset_done;

  assign wr_ctrl     = wr_go && wr_idx_reg == CTRL_IDX;
  assign wr_cmd      = wr_go && wr_idx_reg == CMD_IDX;
  assign key_ok      = wr_data_reg[CMD_KEY_LSB +: 16] == CMD_KEY && wr_strb_reg == 4'hF;
  assign cmd         = cmd_e'(wr_data_reg[1:0]);
  // Keyed commands are ignored while a reset sequence is pending; a malformed one still faults
  assign do_service  = wr_cmd && key_ok && cmd == CMD_SERVICE && seq_reg == ST_RUN;
  assign do_disable  = wr_cmd && key_ok && cmd == CMD_DISABLE && seq_reg == ST_RUN;
  assign do_end_init = wr_cmd && key_ok && cmd == CMD_END_INIT && seq_reg == ST_RUN;
  assign bad_cmd     = wr_cmd && !key_ok && cmd != CMD_NONE;

  // Tick every 2 or every 128 clocks
  assign tick     = prescale_reg ? (pre_reg == PRE_SLOW_LAST) : pre_reg[0];
  assign overflow = seq_reg == ST_RUN && enabled_reg && tick && count_reg == COUNT_MAX;
  assign wdt_reset_done = seq_reg == ST_RESET_SEQ && seq_cnt_reg == 16'(RESET_OUT_LEN - 1);
  assign soft_init = sw_reset_req || wdt_reset_done;

  // Pin synchronisers; the strap pair runs through reset so it is settled when taken
  always_ff @(posedge mclk) begin
    boot_s1_reg <= boot_loader_sel;
    boot_s2_reg <= boot_s1_reg;
    if (!rst_n) begin
      rdy_s1_reg  <= 1'b1;
      rdy_s2_reg  <= 1'b1;
    end else begin
      rdy_s1_reg  <= ext_ready_n;
      rdy_s2_reg  <= rdy_s1_reg;
    end
  end

  // Prescaler restarts on service so the period is exact
  always_ff @(posedge mclk) begin
    if (!rst_n || soft_init || do_service) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // Counter; idle mode has no effect on it
  always_ff @(posedge mclk) begin
    if (!rst_n || soft_init) begin
      count_reg <= COUNT_RESET;
    end else if (do_service) begin
      count_reg <= {reload_reg, {HALF_W{1'b0}}};
    end else if (seq_reg == ST_RUN && enabled_reg && tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Control register
  always_ff @(posedge mclk) begin
    if (!rst_n || soft_init) begin
      reload_reg   <= CTRL_RESET_OTHER[RELOAD_LSB +: HALF_W];
      prescale_reg <= CTRL_RESET_OTHER[PRESCALE_BIT];
    end else if (wr_ctrl) begin
      if (wr_strb_reg[1]) begin
        reload_reg <= wr_data_reg[RELOAD_LSB +: HALF_W];
      end
      if (wr_strb_reg[0]) begin
        prescale_reg <= wr_data_reg[PRESCALE_BIT];
      end
    end
  end

  // Overflow flag: set wins over a service in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (overflow || wdt_reset_done) begin
      flag_reg <= CTRL_RESET_WDT[FLAG_BIT];
    end else if (sw_reset_req || do_service) begin
      flag_reg <= CTRL_RESET_OTHER[FLAG_BIT];
    end
  end

  // Enable and disable window; strap is caught after the hardware reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enabled_reg    <= 1'b0;
      dis_window_reg <= 1'b1;
      strap_wait_reg <= 2'(STRAP_CYCLES);
    end else if (soft_init) begin
      enabled_reg    <= 1'b1;
      dis_window_reg <= 1'b1;
      strap_wait_reg <= '0;
    end else begin
      if (strap_wait_reg != 2'd0) begin
        strap_wait_reg <= strap_wait_reg - 1'b1;
        if (strap_wait_reg == 2'd1) begin
          enabled_reg <= !boot_s2_reg;
        end
      end else if (do_disable && dis_window_reg) begin
        enabled_reg <= 1'b0;
      end
      if (do_service || do_end_init) begin
        dis_window_reg <= 1'b0;
      end
    end
  end

  // Overflow sequence: settle the bus cycle, then hold reset-out low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seq_reg       <= ST_RUN;
      seq_cnt_reg   <= '0;
      ext_bus_abort <= 1'b0;
    end else begin
      ext_bus_abort <= 1'b0;
      case (seq_reg)
        ST_RUN: begin
          seq_cnt_reg <= '0;
          if (overflow) begin
            seq_reg <= ST_BUS_WAIT;
          end
        end
        ST_BUS_WAIT: begin
          if (!ext_bus_busy) begin
            seq_reg <= ST_RESET_SEQ;
          end else if (ext_bus_uses_ready && ext_bus_waits_done && rdy_s2_reg) begin
            ext_bus_abort <= 1'b1;
            seq_reg       <= ST_RESET_SEQ;
          end
        end
        ST_RESET_SEQ: begin
          seq_cnt_reg <= seq_cnt_reg + 1'b1;
          if (wdt_reset_done) begin
            seq_reg <= ST_RUN;
          end
        end
        default: begin
          seq_reg <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reset_out_pin_n  <= 1'b1;
      system_reset_req <= 1'b0;
    end else begin
      // Follows the state a cycle late, so the pin stays low for the full sequence length
      reset_out_pin_n  <= !(seq_reg == ST_RESET_SEQ);
      system_reset_req <= seq_reg == ST_RESET_SEQ;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      protection_fault_trap <= 1'b0;
    end else begin
      protection_fault_trap <= bad_cmd;
    end
  end

  // Interrupt status: a new event beats a clear in the same cycle
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_FAULT]      = bad_cmd;
    irq_set[IRQ_SERVICE]    = do_service;
    irq_set[IRQ_DIS_REJECT] = do_disable && !dis_window_reg;
    irq_clr = '0;
    if (wr_go && wr_idx_reg == IRQ_CLR_IDX && wr_strb_reg[0]) begin
      irq_clr = wr_data_reg[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || soft_init) begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_go && wr_idx_reg == IRQ_EN_IDX && wr_strb_reg[0]) begin
        irq_en_reg <= wr_data_reg[IRQ_W-1:0];
      end
      irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  // AXI write path
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_idx_reg    <= '0;
      wr_data_reg   <= '0;
      wr_strb_reg   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_idx_reg    <= s_axi_awaddr[ADDR_W-1:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_reg  <= s_axi_wdata;
        wr_strb_reg  <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        case (wr_idx_reg)
          CTRL_IDX, COUNT_IDX, CMD_IDX, IRQ_STAT_IDX, IRQ_CLR_IDX, IRQ_EN_IDX, STATE_IDX: begin
            s_axi_bresp <= RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= RESP_DECERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI read path
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        s_axi_rdata   <= '0;
        case (rd_idx)
          CTRL_IDX: begin
            s_axi_rdata <= {16'h0000, reload_reg, 6'h00, flag_reg, prescale_reg};
          end
          COUNT_IDX: begin
            s_axi_rdata <= {16'h0000, count_reg};
          end
          IRQ_STAT_IDX: begin
            s_axi_rdata <= {{(32-IRQ_W){1'b0}}, irq_stat_reg};
          end
          IRQ_EN_IDX: begin
            s_axi_rdata <= {{(32-IRQ_W){1'b0}}, irq_en_reg};
          end
          STATE_IDX: begin
            s_axi_rdata <= {28'h0000000, idle_mode, seq_reg != ST_RUN, dis_window_reg, enabled_reg};
          end
          CMD_IDX, IRQ_CLR_IDX: begin
            s_axi_rdata <= '0;
          end
          default: begin
            s_axi_rresp <= RESP_DECERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: hw/wdt_pkg.sv
package wdt_pkg;

  // Clock and timing
  localparam int CLK_HZ            = 40_000_000;
  localparam int CLK_MHZ           = CLK_HZ / 1_000_000;
  localparam int RESET_OUT_NS      = 1600;
  localparam int RESET_OUT_CYCLES  = (RESET_OUT_NS * CLK_MHZ + 999) / 1000;
  localparam int STRAP_CYCLES      = 2;

  // Counter structure
  localparam int HALF_W            = 8;
  localparam int COUNT_W           = 2 * HALF_W;
  localparam int PRE_W             = 7;
  localparam logic [PRE_W-1:0] PRE_SLOW_LAST = 7'h7F;
  localparam logic [COUNT_W-1:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  // Register indexes; byte address is four times the index
  localparam int ADDR_W            = 18;
  localparam int IDX_W             = 16;
  localparam logic [IDX_W-1:0] CTRL_IDX     = 16'hFFAE;
  localparam logic [IDX_W-1:0] COUNT_IDX    = 16'hFFAF;
  localparam logic [IDX_W-1:0] CMD_IDX      = 16'hFFB0;
  localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 16'hFFB1;
  localparam logic [IDX_W-1:0] IRQ_CLR_IDX  = 16'hFFB2;
  localparam logic [IDX_W-1:0] IRQ_EN_IDX   = 16'hFFB3;
  localparam logic [IDX_W-1:0] STATE_IDX    = 16'hFFB4;

  // Control register fields
  localparam int PRESCALE_BIT      = 0;
  localparam int FLAG_BIT          = 1;
  localparam int RELOAD_LSB        = 8;
  localparam logic [15:0] CTRL_RESET_WDT   = 16'h0002;
  localparam logic [15:0] CTRL_RESET_OTHER = 16'h0000;

  // Command register: key in the upper half, code in the low bits
  localparam int CMD_KEY_LSB       = 16;
  localparam logic [15:0] CMD_KEY  = 16'h5AA5;
  typedef enum logic [1:0] {CMD_NONE, CMD_SERVICE, CMD_DISABLE, CMD_END_INIT} cmd_e;

  // Interrupt status bits
  localparam int IRQ_W             = 3;
  localparam int IRQ_FAULT         = 0;
  localparam int IRQ_SERVICE       = 1;
  localparam int IRQ_DIS_REJECT    = 2;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

// File: testbench/ext_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module ext_bus_model (
  // Clock
  input  wire logic mclk,
  // Hold a ready-gated cycle that never gets ready
  input  wire logic stall,
  // Bus controller status toward the block
  output logic      ext_bus_busy,
  output logic      ext_bus_uses_ready,
  output logic      ext_bus_waits_done,
  output logic      ext_ready_n
);
  // Ready pin has a pull-up, so a slow peripheral never answers
  always_ff @(posedge mclk) begin
    ext_bus_busy       <= stall;
    ext_bus_uses_ready <= stall;
    ext_bus_waits_done <= stall;
    ext_ready_n        <= 1'b1;
  end
endmodule

`default_nettype wire

// File: testbench/watchdog_chk.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_chk #(
  parameter int RESET_OUT_LEN = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Core, pins and bus controller
  input wire logic protection_fault_trap,
  input wire logic system_reset_req,
  input wire logic reset_out_pin_n,
  input wire logic ext_bus_busy,
  input wire logic ext_bus_abort
);
  int low_cnt;

  // Counts how long the reset-out pin has been low
  always_ff @(posedge mclk) begin
    if (!rst_n || reset_out_pin_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_two_later;
    ##2 s_axi_bvalid;
  endsequence

  AST_WR_RESP: assert property (wr_taken |-> resp_two_later)
    else $error("write response not two cycles after take");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after take");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  AST_RST_LEN: assert property ($rose(reset_out_pin_n) |-> low_cnt == RESET_OUT_LEN)
    else $error("reset-out low for wrong length");
  AST_RST_REQ: assert property ($fell(reset_out_pin_n) |-> ##[0:1] system_reset_req)
    else $error("internal reset missing with reset-out");
  AST_FAULT_PULSE: assert property (protection_fault_trap |=> !protection_fault_trap)
    else $error("fault trap longer than one cycle");
  AST_ABORT_BUSY: assert property (ext_bus_abort |-> $past(ext_bus_busy) ##1 !ext_bus_abort)
    else $error("abort without a running bus cycle");

endmodule

`default_nettype wire

// File: testbench/watchdog_timer_with_reload_tb.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_with_reload_tb;
  import wdt_pkg::*;
  localparam int RLEN = 4;
  logic              mclk = 0, rst_n = 0, sw_reset_req = 0, idle_mode = 0, boot_loader_sel = 0, stall = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic [2:0]        s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              protection_fault_trap, system_reset_req, ext_ready_n, reset_out_pin_n, irq;
  logic              ext_bus_busy, ext_bus_uses_ready, ext_bus_waits_done, ext_bus_abort;
  logic              fault_seen = 0, abort_seen = 0;
  int                failures = 0, checks_done = 0, n;

  watchdog_timer_with_reload #(.RESET_OUT_LEN(RLEN)) watchdog_timer_with_reload_inst (.*);
  ext_bus_model ext_bus_model_inst (.mclk, .stall, .ext_bus_busy, .ext_bus_uses_ready,
                                    .ext_bus_waits_done, .ext_ready_n);

  always #12.5 mclk = ~mclk;

  // One-cycle pulses are latched so a scenario can look at them later
  always @(posedge mclk) begin
    if (protection_fault_trap === 1'b1) fault_seen <= 1'b1;
    if (ext_bus_abort === 1'b1) abort_seen <= 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic hw_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // Handshakes are judged at the negedge, where the sampled values are settled
  task automatic wr(input logic [15:0] idx, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    logic a, w;
    a = 0;
    w = 0;
    @(posedge mclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(negedge mclk);
      a = a | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      @(posedge mclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge mclk); while (s_axi_bvalid !== 1'b1);
    check(s_axi_bresp, er);
    @(posedge mclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] v);
    @(posedge mclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge mclk); while (s_axi_arready !== 1'b1);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge mclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    check(s_axi_rresp, RESP_OKAY);
    @(posedge mclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    rd(idx, d);
    check(d, exp);
  endtask

  task automatic cmd(input cmd_e c);
    wr(CMD_IDX, {CMD_KEY, 14'h0000, c});
  endtask

  task automatic wait_fall(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge mclk);
      cnt++;
    end while (reset_out_pin_n === 1'b1 && cnt < lim);
    while (reset_out_pin_n !== 1'b1) @(negedge mclk);
    repeat (4) @(posedge mclk);
  endtask

  task automatic t_after_reset();
    rdc(CTRL_IDX, 32'h0000_0000);
    rdc(STATE_IDX, 32'h0000_0003);
    wr(COUNT_IDX, 32'h0000_FFFF);
    rd(COUNT_IDX, d);
    check(d < 32'h100, 1);
    wr(16'h0123, 32'h0, RESP_DECERR);
    wr(CTRL_IDX, 32'h0000_AB03);
    rdc(CTRL_IDX, 32'h0000_AB01);
    wr(CTRL_IDX, 32'h0000_0000);
  endtask

  task automatic t_late_disable();
    wr(IRQ_EN_IDX, 32'h4);
    cmd(CMD_END_INIT);
    cmd(CMD_DISABLE);
    rdc(STATE_IDX, 32'h0000_0001);
    check(irq, 1'b1);
    rdc(IRQ_STAT_IDX, 32'h4);
    wr(IRQ_CLR_IDX, 32'h4);
    rdc(IRQ_STAT_IDX, 32'h0);
    check(irq, 1'b0);
    wr(IRQ_EN_IDX, 32'h0);
    cmd(CMD_DISABLE);
    rdc(IRQ_STAT_IDX, 32'h4);
    check(irq, 1'b0);
    wr(IRQ_CLR_IDX, 32'h4);
  endtask

  task automatic t_bad_key();
    fault_seen = 0;
    wr(CMD_IDX, {16'hA55A, 16'h0001});
    repeat (2) @(posedge mclk);
    check(fault_seen, 1'b1);
    rdc(IRQ_STAT_IDX, 32'h1);
    wr(IRQ_CLR_IDX, 32'h1);
  endtask

  // Preset FF at divide-by-2 expires after 2 * 256 clocks
  task automatic t_fast_overflow();
    idle_mode <= 1'b1;
    wr(CTRL_IDX, 32'h0000_FF00);
    cmd(CMD_SERVICE);
    wait_fall(2000, n);
    check(n >= 505 && n <= 520, 1);
    rdc(CTRL_IDX, 32'h0000_0002);
    rdc(STATE_IDX, 32'h0000_000B);
    idle_mode <= 1'b0;
    cmd(CMD_SERVICE);
    rdc(CTRL_IDX, 32'h0000_0000);
  endtask

  // Divide-by-128 with a bus cycle that never sees ready
  task automatic t_slow_abort();
    wr(CTRL_IDX, 32'h0000_FF01);
    cmd(CMD_SERVICE);
    stall <= 1'b1;
    abort_seen = 0;
    wait_fall(40000, n);
    check(n >= 32760 && n <= 32780, 1);
    check(abort_seen, 1'b1);
    stall <= 1'b0;
  endtask

  task automatic t_early_disable();
    @(posedge mclk);
    sw_reset_req <= 1'b1;
    @(posedge mclk);
    sw_reset_req <= 1'b0;
    repeat (3) @(posedge mclk);
    rdc(CTRL_IDX, 32'h0000_0000);
    cmd(CMD_DISABLE);
    rd(STATE_IDX, d);
    check(d[0], 1'b0);
    rd(COUNT_IDX, d);
    wait_fall(600, n);
    check(n, 600);
    rdc(COUNT_IDX, d);
  endtask

  task automatic t_boot();
    boot_loader_sel <= 1'b1;
    hw_reset();
    rd(STATE_IDX, d);
    check(d[0], 1'b0);
    boot_loader_sel <= 1'b0;
    hw_reset();
    rdc(STATE_IDX, 32'h0000_0003);
  endtask

  initial begin
    hw_reset();
    t_after_reset();
    t_late_disable();
    t_bad_key();
    t_fast_overflow();
    t_slow_abort();
    t_early_disable();
    t_boot();
    summarize();
  end

  // Whole run is near 40000 cycles; twice that means a hang
  initial begin
    #2000000;
    failures++;
    summarize();
  end
endmodule

bind watchdog_timer_with_reload watchdog_chk #(.RESET_OUT_LEN(RESET_OUT_LEN)) watchdog_chk_inst (.*);

`default_nettype wire
